/* File: logic/button_debouncer.sv */
// tick-based debouncer with separate press and release hold counts
// assumes raw is already synchronised and tick is a one-cycle enable
`timescale 1ns/100ps
module button_debouncer
  import pmic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic raw,
  input wire logic [DB_W-1:0] rise_ticks,
  input wire logic [DB_W-1:0] fall_ticks,
  output logic level,
  output logic rise,
  output logic fall
);

  dbnc_st_t s;
  dbnc_st_t n;
  logic [DB_W-1:0] thr;

  // count ticks while the input differs, flip once the hold is met
  always_comb begin
    n = s;
    n.rise = 1'b0;
    n.fall = 1'b0;
    thr = raw ? rise_ticks : fall_ticks;
    if (raw == s.level) begin
      n.cnt = '0;
    end else if (tick) begin
      if (s.cnt + 5'h01 >= thr) begin
        n.level = raw;
        n.cnt = '0;
        n.rise = raw;
        n.fall = ~raw;
      end else begin
        n.cnt = s.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.level;
  assign rise = s.rise;
  assign fall = s.fall;

endmodule

/* File: logic/pmic_pkg.sv */
// package for the power-state controller: timing, register map, state types
// assumes a single 50 MHz clock and a 31.25 ms internal slow tick
package pmic_pkg;

  // clock and slow tick
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 31250;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TCNT_W = 21;

  // debounce and hold times in their own units, then in ticks
  localparam int DBNC_SHORT_US = 31250;
  localparam int DBNC_MID_US = 125000;
  localparam int DBNC_LONG_US = 750000;
  localparam int LONG_PRESS_MIN_S = 4;
  localparam int PIN_LONG_S = 4;
  localparam int WAKE_PRESS_MS = 1000;
  localparam int DB_W = 5;
  localparam int CNT_W = 10;
  localparam logic [DB_W-1:0] DBNC_SHORT_T = DB_W'(DBNC_SHORT_US / TICK_US);
  localparam logic [DB_W-1:0] DBNC_MID_T = DB_W'(DBNC_MID_US / TICK_US);
  localparam logic [DB_W-1:0] DBNC_LONG_T = DB_W'(DBNC_LONG_US / TICK_US);
  localparam logic [CNT_W-1:0] LP_UNIT_T = CNT_W'(LONG_PRESS_MIN_S * 1_000_000 / TICK_US);
  localparam logic [CNT_W-1:0] PIN_LONG_T = CNT_W'(PIN_LONG_S * 1_000_000 / TICK_US);
  localparam logic [CNT_W-1:0] WAKE_T = CNT_W'(WAKE_PRESS_MS * 1000 / TICK_US);

  // regulators and sequence slots
  localparam int NREG = 6;
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h7;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h1;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_REL_BIT = 4;
  localparam int ST_IRQ_BIT = 5;
  localparam int ST_REG_LSB = 6;

  // pin sync vector positions and idle levels
  localparam int PIN_BTN = 0;
  localparam int PIN_STBY = 1;
  localparam int PIN_PON = 2;
  localparam int PIN_WDG = 3;
  localparam logic [3:0] PIN_IDLE = 4'h9;

  typedef enum logic [2:0] {PS_REGS_OFF, PS_DEEP_OFF, PS_RUN, PS_STANDBY, PS_SLEEP} pstate_t;

  // software control bits, reset to all zero
  typedef struct packed {
    logic [1:0] long_press_time_sel;
    logic [1:0] button_debounce_sel;
    logic button_reset_enable;
    logic power_pin_reset_enable;
    logic power_pin_mode_sel;
    logic standby_polarity_invert;
  } ctl_cfg_t;
  localparam ctl_cfg_t CTL_RST = '0;

  // programmed regulator plan
  typedef struct packed {
    logic [NREG*SLOT_W-1:0] slot;
    logic [NREG-1:0] run_en;
    logic [NREG-1:0] stby_en;
    logic [NREG-1:0] sleep_en;
    logic [NREG-1:0] stby_lowv;
    logic [NREG-1:0] sleep_lowv;
  } reg_cfg_t;

  // supervisor levels
  typedef struct packed {
    logic vsys_ok;
    logic temp_ok;
    logic therm_shdn;
  } sys_stat_t;

  typedef struct packed {
    logic level;
    logic [DB_W-1:0] cnt;
    logic rise;
    logic fall;
  } dbnc_st_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [TCNT_W-1:0] tcnt;
    logic tick;
    pstate_t pstate;
    logic busy;
    logic dir_up;
    logic [SLOT_W-1:0] slot;
    logic [NREG-1:0] tgt_en;
    logic [NREG-1:0] tgt_lowv;
    logic [NREG-1:0] reg_en;
    logic [NREG-1:0] reg_lowv;
    logic rst_rel;
    logic irq;
    logic [CNT_W-1:0] press_cnt;
    logic [CNT_W-1:0] pon_cnt;
    logic pon_prev;
    logic pon_fall_seen;
    ctl_cfg_t ctl;
    logic [DATA_W-1:0] rdata;
  } st_t;

endpackage

/* File: logic/pmic_power_state_controller.sv */
// power-state controller: button debounce, power states, regulator sequencing
// assumes pins arrive from outside, regulator plan is strapped, slow tick is derived here
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module pmic_power_state_controller
  import pmic_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POWER_BUTTON_IN,
  input wire logic STANDBY_IN,
  input wire logic POWER_ON_IN,
  input wire logic WATCHDOG_IN,
  input wire sys_stat_t SYS,
  input wire reg_cfg_t REG_CFG,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  output logic [NREG-1:0] REG_EN,
  output logic [NREG-1:0] REG_LOWV,
  output logic RTC_SUPPLY_EN,
  output logic HOST_RESET_OUT_N,
  output logic HOST_RESET_OE,
  output logic BUTTON_IRQ,
  output pstate_t STATE
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** TCNT_W) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  localparam st_t ST_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, pstate: PS_REGS_OFF, ctl: CTL_RST, default: '0};

  st_t s;
  st_t n;
  logic btn_raw;
  logic pressed;
  logic btn_rise;
  logic [DB_W-1:0] fall_thr;
  logic [CNT_W-1:0] long_thr;
  logic long_hit;
  logic wake_hit;
  logic pon;
  logic pon_fall;
  logic pon_rise;
  logic pon_long;
  logic stby_req;
  logic any_keep;
  logic wdg_low;
  logic turn_on;
  logic turn_off;
  logic sleep_req;
  logic powered;
  logic go;
  pstate_t dst;
  logic [NREG-1:0] slot_hit;
  logic [DATA_W-1:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // slot match per regulator
  for (genvar i = 0; i < NREG; i++) begin : g_slot
    assign slot_hit[i] = REG_CFG.slot[i*SLOT_W +: SLOT_W] == s.slot;
  end

  // press debounce from select, release fixed short
  always_comb begin
    unique case (s.ctl.button_debounce_sel)
      2'b10: fall_thr = DBNC_MID_T;
      2'b11: fall_thr = DBNC_LONG_T;
      default: fall_thr = DBNC_SHORT_T;
    endcase
  end

  assign btn_raw = ~s.s2[PIN_BTN];

  button_debouncer u_dbnc (
    .clk(CLK),
    .rst(RST),
    .tick(s.tick),
    .raw(btn_raw),
    .rise_ticks(fall_thr),
    .fall_ticks(DBNC_SHORT_T),
    .level(pressed),
    .rise(),
    .fall(btn_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  assign long_thr = LP_UNIT_T * {8'h00, s.ctl.long_press_time_sel} + LP_UNIT_T;
  assign long_hit = pressed & s.tick & (s.press_cnt + 10'h001 == long_thr);
  assign wake_hit = pressed & s.tick & (s.press_cnt + 10'h001 == WAKE_T);
  assign pon = s.s2[PIN_PON];
  assign pon_fall = s.pon_prev & ~pon;
  assign pon_rise = ~s.pon_prev & pon;
  assign pon_long = ~pon & s.tick & (s.pon_cnt + 10'h001 == PIN_LONG_T);
  assign stby_req = s.s2[PIN_STBY] ^ s.ctl.standby_polarity_invert;
  assign any_keep = |REG_CFG.sleep_en;
  assign wdg_low = ~s.s2[PIN_WDG] & s.rst_rel; // masked until reset released
  assign powered = s.pstate inside {PS_RUN, PS_STANDBY, PS_SLEEP};

  // turn-on: level or falling edge, gated by supervisors
  assign turn_on = SYS.vsys_ok & SYS.temp_ok & (s.ctl.power_pin_mode_sel ? pon_fall : pon);

  // turn-off sources
  assign turn_off = SYS.therm_shdn | wdg_low
    | (long_hit & s.ctl.button_reset_enable)
    | (~s.ctl.power_pin_mode_sel & ~pon & ~any_keep)
    | (s.ctl.power_pin_mode_sel & pon_long & s.ctl.power_pin_reset_enable
       & (~any_keep | (s.pstate == PS_SLEEP)));

  // sleep request only if some regulator stays up in sleep
  assign sleep_req = any_keep & (s.ctl.power_pin_mode_sel ? (pon_long & s.ctl.power_pin_reset_enable) : ~pon);

  // status word
  always_comb begin
    status = '0;
    status[2:0] = s.pstate;
    status[ST_BUSY_BIT] = s.busy;
    status[ST_REL_BIT] = s.rst_rel;
    status[ST_IRQ_BIT] = s.irq;
    status[ST_REG_LSB +: NREG] = s.reg_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = s;
    go = 1'b0;
    dst = s.pstate;
    // two-stage pin synchroniser
    n.s1 = {WATCHDOG_IN, POWER_ON_IN, STANDBY_IN, POWER_BUTTON_IN};
    n.s2 = s.s1;
    // slow tick divider
    n.tick = 1'b0;
    if (s.tcnt == TCNT_W'(TICK_CYCLES - 1)) begin
      n.tcnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tcnt = s.tcnt + 21'h000001;
    end
    // hold timers, saturating
    if (!pressed) begin
      n.press_cnt = '0;
    end else if (s.tick && s.press_cnt != '1) begin
      n.press_cnt = s.press_cnt + 10'h001;
    end
    if (pon) begin
      n.pon_cnt = '0;
    end else if (s.tick && s.pon_cnt != '1) begin
      n.pon_cnt = s.pon_cnt + 10'h001;
    end
    n.pon_prev = pon;
    if (s.pstate != PS_SLEEP) begin
      n.pon_fall_seen = 1'b0;
    end else if (pon_fall) begin
      n.pon_fall_seen = 1'b1;
    end
    // state transitions
    if (powered && turn_off) begin
      go = 1'b1;
      dst = PS_REGS_OFF;
    end else if (!s.busy) begin
      unique case (s.pstate)
        PS_REGS_OFF: begin
          if (turn_on) begin
            go = 1'b1;
            dst = PS_RUN;
          end else if (long_hit) begin
            go = 1'b1;
            dst = PS_DEEP_OFF;
          end
        end
        PS_DEEP_OFF: begin
          if (wake_hit) begin
            go = 1'b1;
            dst = PS_REGS_OFF;
          end
        end
        PS_RUN: begin
          if (sleep_req) begin
            go = 1'b1;
            dst = PS_SLEEP;
          end else if (stby_req) begin
            go = 1'b1;
            dst = PS_STANDBY;
          end
        end
        PS_STANDBY: begin
          if (sleep_req) begin
            go = 1'b1;
            dst = PS_SLEEP;
          end else if (!stby_req) begin
            go = 1'b1;
            dst = PS_RUN;
          end
        end
        PS_SLEEP: begin
          if (s.ctl.power_pin_mode_sel ? (s.pon_fall_seen & pon_rise) : pon) begin
            go = 1'b1;
            dst = PS_RUN;
          end
        end
      endcase
    end
    // release host reset only once the run sequence has fully finished
    if (s.pstate == PS_RUN && !s.busy) begin
      n.rst_rel = 1'b1;
    end
    // load a sequence toward the destination
    if (go) begin
      n.pstate = dst;
      n.busy = 1'b1;
      n.dir_up = dst == PS_RUN;
      n.slot = (dst == PS_RUN) ? '0 : SLOT_LAST;
      unique case (dst)
        PS_RUN: begin
          n.tgt_en = REG_CFG.run_en;
          n.tgt_lowv = '0;
        end
        PS_STANDBY: begin
          n.tgt_en = REG_CFG.stby_en;
          n.tgt_lowv = REG_CFG.stby_lowv;
        end
        PS_SLEEP: begin
          n.tgt_en = REG_CFG.sleep_en;
          n.tgt_lowv = REG_CFG.sleep_lowv;
        end
        default: begin
          n.tgt_en = '0;
          n.tgt_lowv = '0;
        end
      endcase
      if (dst == PS_REGS_OFF || dst == PS_DEEP_OFF) begin
        n.rst_rel = 1'b0;
      end
    end else if (s.busy && s.tick) begin
      // walk one slot per tick: up ascending, down descending
      for (int i = 0; i < NREG; i++) begin
        if (slot_hit[i]) begin
          n.reg_en[i] = s.tgt_en[i];
          n.reg_lowv[i] = s.tgt_lowv[i];
        end
      end
      if (s.slot == (s.dir_up ? SLOT_LAST : 3'h0)) begin
        n.busy = 1'b0;
      end else begin
        n.slot = s.dir_up ? s.slot + 3'h1 : s.slot - 3'h1;
      end
    end
    // register writes
    if (WR && ADDR == CTRL_OFS) begin
      n.ctl = ctl_cfg_t'(WDATA[7:0]);
    end
    // interrupt flag: set wins over both clears
    if (btn_rise) begin
      n.irq = 1'b1;
    end else if ((go && dst == PS_REGS_OFF) || (WR && ADDR == STATUS_OFS && WDATA[ST_IRQ_BIT])) begin
      n.irq = 1'b0;
    end
    // read data, present only the cycle after the strobe
    n.rdata = '0;
    if (RD) begin
      if (ADDR == CTRL_OFS) begin
        n.rdata = {8'h00, s.ctl};
      end else if (ADDR == STATUS_OFS) begin
        n.rdata = status;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA = s.rdata;
  assign REG_EN = s.reg_en;
  assign REG_LOWV = s.reg_lowv;
  assign RTC_SUPPLY_EN = 1'b1;
  assign HOST_RESET_OUT_N = 1'b0;
  assign HOST_RESET_OE = ~s.rst_rel;
  assign BUTTON_IRQ = s.irq;
  assign STATE = s.pstate;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  btn_low_press_a: assert property ($rose(pressed) |-> $past(~s.s2[PIN_BTN]))
    else $error("press seen without low pin");
  long_press_off_a: assert property (powered && long_hit && s.ctl.button_reset_enable |=>
    s.pstate == PS_REGS_OFF) else $error("long press did not turn off");
  release_short_a: assert property (pressed && !btn_raw && s.tick |=> !pressed)
    else $error("release not on a tick");
  irq_set_a: assert property (btn_rise |=> s.irq)
    else $error("release did not set flag");
  irq_off_clear_a: assert property (go && dst == PS_REGS_OFF && !btn_rise |=> !s.irq)
    else $error("flag survived regs off");
  off_exit_a: assert property (s.pstate == PS_REGS_OFF |=>
    s.pstate inside {PS_REGS_OFF, PS_DEEP_OFF, PS_RUN}) else $error("bad exit from regs off");
  deep_exit_a: assert property (s.pstate == PS_DEEP_OFF |=>
    s.pstate inside {PS_DEEP_OFF, PS_REGS_OFF}) else $error("bad exit from deep off");
  turn_off_a: assert property (powered && turn_off |=> s.pstate == PS_REGS_OFF)
    else $error("turn off missed");
  regs_all_off_a: assert property (!powered && !s.busy |-> REG_EN == '0 && RTC_SUPPLY_EN)
    else $error("regulator on while off");
  reset_order_a: assert property ($rose(s.rst_rel) |-> $past(s.pstate) == PS_RUN && !$past(s.busy)
    && $past(REG_EN) == $past(s.tgt_en)) else $error("reset released early");
  stby_entry_a: assert property ($changed(s.pstate) && s.pstate == PS_STANDBY |->
    $past(s.pstate) == PS_RUN && $past(stby_req)) else $error("bad standby entry");
  down_order_a: assert property (s.busy && !s.dir_up && s.tick && s.slot != 3'h0 && !go |=>
    s.slot == $past(s.slot) - 3'h1) else $error("power-down order broken");
  low_power_rel_a: assert property (s.pstate inside {PS_STANDBY, PS_SLEEP} |-> !HOST_RESET_OE)
    else $error("reset asserted in low power");
  off_reset_a: assert property (!powered |-> HOST_RESET_OE)
    else $error("reset released while off");

  run_entry_c: cover property (s.pstate == PS_REGS_OFF ##1 s.pstate == PS_RUN ##[1:300] s.rst_rel);
  stby_sleep_c: cover property (s.pstate == PS_STANDBY ##1 s.pstate == PS_SLEEP);
  sleep_wake_c: cover property (s.pstate == PS_SLEEP ##1 s.pstate == PS_RUN);
  long_press_c: cover property (powered && long_hit && s.ctl.button_reset_enable);

endmodule

/* File: sim/host_side_model.sv */
// push button and host processor pins facing the power-state controller
// assumes the bench calls the tasks; host reset wire has a pull-up
`timescale 1ns/100ps
module host_side_model
  import pmic_pkg::*;
(
  input wire logic clk,
  input wire logic host_reset_oe,
  input wire logic host_reset_n,
  output logic button_n,
  output logic standby,
  output logic power_on,
  output logic watchdog_n,
  output logic host_released
);
  ////////////////////////////////////////////////////////////////////////////
  // open-drain reset line: pulled high unless the device drives it
  assign host_released = host_reset_oe ? host_reset_n : 1'b1;

  // idle pins: button up, watchdog quiet
  initial begin
    button_n = 1'b1;
    standby = 1'b0;
    power_on = 1'b0;
    watchdog_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold the button down for a number of cycles, low while pressed
  task automatic press(input int cyc);
    @(posedge clk);
    button_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    button_n <= 1'b1;
  endtask

  // host requests through standby, power-on and watchdog pins
  task automatic set_pins(input logic sb, input logic po, input logic wd);
    @(posedge clk);
    standby <= sb;
    power_on <= po;
    watchdog_n <= wd;
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the power-state controller
// assumes the host-side model drives the pins and a four-cycle slow tick
`timescale 1ns/100ps
module tb_top
  import pmic_pkg::*;
;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sys_stat_t sys;
  reg_cfg_t cfg;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [DATA_W-1:0] rdata, rv;
  logic [NREG-1:0] reg_en, reg_lowv;
  logic [NREG-1:0] en_q = '0;
  logic rtc_en, hr_n, hr_oe, irq, btn_n, stby, pon, wdg_n, released;
  pstate_t state;
  pstate_t m_state = PS_REGS_OFF;
  logic m_irq = 1'b0;
  int fails = 0, samples_checked = 0, seed = 32'hcbfe, cyc = 0, t_rel = 0, dbt;
  int t_on [NREG];

  pmic_power_state_controller #(.TICK_CYCLES(TK)) i_pmic_power_state_controller (
    .CLK(clk), .RST(rst), .POWER_BUTTON_IN(btn_n), .STANDBY_IN(stby), .POWER_ON_IN(pon),
    .WATCHDOG_IN(wdg_n), .SYS(sys), .REG_CFG(cfg), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .REG_EN(reg_en), .REG_LOWV(reg_lowv), .RTC_SUPPLY_EN(rtc_en),
    .HOST_RESET_OUT_N(hr_n), .HOST_RESET_OE(hr_oe), .BUTTON_IRQ(irq), .STATE(state));

  host_side_model i_host_side_model (
    .clk(clk), .host_reset_oe(hr_oe), .host_reset_n(hr_n), .button_n(btn_n), .standby(stby),
    .power_on(pon), .watchdog_n(wdg_n), .host_released(released));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  always #10 clk = ~clk;

  // cycle count, enable rise times, reset release time, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    en_q <= reg_en;
    for (int i = 0; i < NREG; i++) begin
      if (reg_en[i] && !en_q[i]) t_on[i] = cyc;
    end
    if (!hr_oe && released && t_rel == 0) t_rel = cyc;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished at %0t", n, $time);
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // register port cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  // model of outputs for the expected state
  task automatic check_all();
    logic [NREG-1:0] e, l;
    logic up;
    up = m_state inside {PS_RUN, PS_STANDBY, PS_SLEEP};
    e = m_state == PS_RUN ? cfg.run_en : m_state == PS_STANDBY ? cfg.stby_en :
        m_state == PS_SLEEP ? cfg.sleep_en : '0;
    l = m_state == PS_STANDBY ? cfg.stby_lowv : m_state == PS_SLEEP ? cfg.sleep_lowv : '0;
    chk(16'(state), 16'(m_state));
    chk(16'(reg_en), 16'(e));
    chk(16'(reg_lowv), 16'(l));
    chk(16'(hr_oe), 16'(!up));
    chk(16'(released), 16'(up));
    chk(16'(rtc_en), 16'h0001);
    chk(16'(irq), 16'(m_irq));
    rd(STATUS_OFS, rv);
    chk(16'(rv[11:0]), 16'({e, m_irq, up, 1'b0, 3'(m_state)}));
  endtask

  // wait for a state, let the sequence finish, then compare
  task automatic go(input pstate_t s, input logic ir);
    for (int i = 0; i < 200 && state !== s; i++) @(posedge clk);
    repeat (12 * TK) @(posedge clk);
    m_state = s;
    m_irq = ir;
    check_all();
  endtask

  task automatic edge_on();
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b1);
    repeat (4 * TK) @(posedge clk);
    i_host_side_model.set_pins(1'b0, 1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys = '{vsys_ok: 1'b0, temp_ok: 1'b1, therm_shdn: 1'b0};
    cfg = reg_cfg_t'(48'({$random(seed), $random(seed)}));
    cfg.run_en[0] = 1'b1;
    cfg.sleep_en[0] = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_OFS, rv);
    chk(rv, 16'h0000);
    rd(4'hf, rv);
    chk(rv, 16'h0000);
    check_all();
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b1);
    go(PS_REGS_OFF, 1'b0);
    sys.vsys_ok <= 1'b1;
    go(PS_RUN, 1'b0);
    for (int i = 0; i < NREG; i++) begin
      chk(16'(t_rel > t_on[i] || !cfg.run_en[i]), 16'h0001);
      for (int j = 0; j < NREG; j++) begin
        if (cfg.run_en[i] && cfg.run_en[j] && cfg.slot[i*3 +: 3] < cfg.slot[j*3 +: 3])
          chk(16'(t_on[i] < t_on[j]), 16'h0001);
      end
    end
    done("power up");
    i_host_side_model.set_pins(1'b1, 1'b1, 1'b1);
    go(PS_STANDBY, 1'b0);
    i_host_side_model.set_pins(1'b1, 1'b0, 1'b1);
    go(PS_SLEEP, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b0, 1'b1);
    go(PS_SLEEP, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b1);
    go(PS_RUN, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b0, 1'b1);
    go(PS_SLEEP, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b1);
    go(PS_RUN, 1'b0);
    wr(CTRL_OFS, 16'h0001);
    go(PS_STANDBY, 1'b0);
    i_host_side_model.set_pins(1'b1, 1'b1, 1'b1);
    go(PS_RUN, 1'b0);
    wr(CTRL_OFS, 16'h0000);
    go(PS_STANDBY, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b1);
    go(PS_RUN, 1'b0);
    done("standby and sleep");
    for (int sel = 0; sel < 4; sel++) begin
      dbt = sel == 3 ? 24 : sel == 2 ? 4 : 1;
      wr(CTRL_OFS, 16'(sel << 4));
      if (sel > 1) begin
        i_host_side_model.press((dbt - 2) * TK);
        go(PS_RUN, 1'b0);
      end
      i_host_side_model.press((dbt + 3) * TK);
      go(PS_RUN, 1'b1);
      wr(STATUS_OFS, 16'h0020);
      go(PS_RUN, 1'b0);
    end
    done("debounce");
    wr(CTRL_OFS, 16'h0002);
    i_host_side_model.press(140 * TK);
    go(PS_RUN, 1'b1);
    i_host_side_model.set_pins(1'b0, 1'b1, 1'b0);
    go(PS_REGS_OFF, 1'b0);
    i_host_side_model.set_pins(1'b0, 1'b0, 1'b1);
    go(PS_RUN, 1'b0);
    sys.therm_shdn <= 1'b1;
    go(PS_REGS_OFF, 1'b0);
    sys.therm_shdn <= 1'b0;
    sys.temp_ok <= 1'b0;
    edge_on();
    go(PS_REGS_OFF, 1'b0);
    sys.temp_ok <= 1'b1;
    edge_on();
    go(PS_RUN, 1'b0);
    done("turn off events");
    wr(CTRL_OFS, 16'h000a);
    i_host_side_model.press(129 * TK + 24);
    go(PS_REGS_OFF, 1'b1);
    done("long press");
    wr(CTRL_OFS, 16'h004a);
    i_host_side_model.press(257 * TK + 24);
    go(PS_DEEP_OFF, 1'b1);
    i_host_side_model.press(33 * TK + 24);
    go(PS_REGS_OFF, 1'b1);
    done("deep off");
    summarize();
  end
endmodule
